// >>> ctmsr_map.vh
// Register map, field positions and key values of the codec tie-off and mute register slice
`ifndef CTMSR_MAP_VH
`define CTMSR_MAP_VH

// Register indices; the byte address is four times the index
`define CTMSR_IDX_OUT_OVR 9'h04f
`define CTMSR_IDX_KEY1 9'h057
`define CTMSR_IDX_KEY2 9'h06c
`define CTMSR_IDX_KEY3 9'h073
`define CTMSR_IDX_MUTE 9'h07c
`define CTMSR_IDX_IRQ_STAT 9'h07d
`define CTMSR_IDX_IRQ_MASK 9'h07e

// Bus geometry
`define CTMSR_AW 12
`define CTMSR_DW 32
`define CTMSR_RW 9
`define CTMSR_PAD_W 23
`define CTMSR_IDX_LSB 2
// Byte-lane bits of an aligned word address
`define CTMSR_ALIGN_OK 2'h0

// Tie-off switch count and reset state
`define CTMSR_SW_W 6
`define CTMSR_RST6 6'h00

// Reset values
`define CTMSR_RST9 9'h000
`define CTMSR_RST3 3'h0
`define CTMSR_RST32 32'h0000_0000

// Output override register fields
`define CTMSR_OVR_EN 8
`define CTMSR_OVR_BUFH 7
`define CTMSR_OVR_BUFL 6
`define CTMSR_OVR_SW_HI 5
`define CTMSR_OVR_SW_LO 0

// Mute status fields (also the layout of interrupt status and mask)
`define CTMSR_MUTE_ANA 2
`define CTMSR_MUTE_LEFT 1
`define CTMSR_MUTE_RIGHT 0
`define CTMSR_EV_W 3

// Four-wire mode key values
`define CTMSR_KEY1_VAL 9'h115
`define CTMSR_KEY2_VAL 9'h03b
`define CTMSR_KEY3_VAL 9'h129

// Digital gain width and zero value
`define CTMSR_GAIN_W 8
`define CTMSR_GAIN_ZERO 8'h00

`endif

// >>> ctmsr_regs.v
// Tie-off override, mute status and four-wire key registers behind an APB slave
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "ctmsr_map.vh"

module ctmsr_regs (
  input wire CLK_I, // 25 MHz clock
  input wire RESET_N_I, // Synchronous reset, active low
  input wire PSEL_I, // APB select
  input wire PENABLE_I, // APB enable
  input wire PWRITE_I, // APB direction, high for write
  input wire [`CTMSR_AW-1:0] PADDR_I, // APB byte address
  input wire [`CTMSR_DW-1:0] PWDATA_I, // APB write data
  output reg [`CTMSR_DW-1:0] PRDATA_O, // APB read data
  output reg PREADY_O, // APB ready
  output reg PSLVERR_O, // APB error on unmapped address
  input wire ANALOG_AUTOMUTE_I, // Analog automute condition active
  input wire [`CTMSR_GAIN_W-1:0] LEFT_GAIN_I, // Left playback digital gain
  input wire [`CTMSR_GAIN_W-1:0] RIGHT_GAIN_I, // Right playback digital gain
  input wire BOOST_BUF_EN_I, // Boosted tie-off buffer enabled
  input wire PLAIN_BUF_EN_I, // Plain tie-off buffer enabled
  input wire AUTO_BOOST_BYP_I, // Automatic boosted bypass switch state
  input wire AUTO_PLAIN_BYP_I, // Automatic plain bypass switch state
  input wire [5:0] AUTO_TIEOFF_I, // Automatic tie-off switches, order as outputs
  output reg BOOST_BYP_CLOSE_O, // Boosted buffer bypass switch closed
  output reg PLAIN_BYP_CLOSE_O, // Plain buffer bypass switch closed
  output reg [5:0] TIEOFF_CLOSE_O, // Spk L, spk R, aux A, aux B, phones L, phones R
  output reg FOUR_WIRE_MODE_O, // Four-wire control mode enabled
  output reg IRQ_O // Level interrupt
);

  // ==========================================================
  // Declarations
  reg [`CTMSR_RW-1:0] ovr_q;
  reg [`CTMSR_RW-1:0] key1_q;
  reg [`CTMSR_RW-1:0] key2_q;
  reg [`CTMSR_RW-1:0] key3_q;
  reg [`CTMSR_EV_W-1:0] mute_q;
  reg [`CTMSR_EV_W-1:0] mute_d;
  reg [`CTMSR_EV_W-1:0] irq_stat_q;
  reg [`CTMSR_EV_W-1:0] irq_stat_d;
  reg [`CTMSR_EV_W-1:0] irq_mask_q;
  reg [`CTMSR_RW-1:0] rd_d;
  reg hit_d;
  wire [`CTMSR_RW-1:0] idx;
  wire setup_ph;
  wire wr_ok;
  wire ovr_en;
  wire [`CTMSR_EV_W-1:0] mute_rise;
  reg [`CTMSR_DW-1:0] prdata_d;
  reg pslverr_d;
  reg boost_byp_d;
  reg plain_byp_d;
  wire [`CTMSR_SW_W-1:0] tieoff_d;
  reg four_wire_d;
  reg irq_d;
  wire addr_aligned;
  wire addr_in_page;
  wire wr_ovr;
  wire wr_key1;
  wire wr_key2;
  wire wr_key3;
  wire wr_mask;
  wire clr_stat;
  wire key1_ok;
  wire key2_ok;
  wire key3_ok;

  // ==========================================================
  // Bus phase decode
  // The register index sits above the two byte-lane bits
  assign idx = PADDR_I[`CTMSR_IDX_LSB +: `CTMSR_RW];
  assign setup_ph = PSEL_I & ~PENABLE_I;
  // Write commits only at the access edge that sees ready high
  assign wr_ok = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I & ~PSLVERR_O;

  // Byte-lane bits must be zero; the top address bit lies outside the
  // index, so without this check every register would show up twice
  assign addr_aligned = (PADDR_I[`CTMSR_IDX_LSB-1:0] == `CTMSR_ALIGN_OK);
  assign addr_in_page = ~|PADDR_I[`CTMSR_AW-1:`CTMSR_IDX_LSB+`CTMSR_RW];

  // ==========================================================
  // Write strobes, one per writable place
  // Unmapped accesses never get here, since PSLVERR_O blocks wr_ok
  assign wr_ovr = wr_ok && (idx == `CTMSR_IDX_OUT_OVR);
  assign wr_key1 = wr_ok && (idx == `CTMSR_IDX_KEY1);
  assign wr_key2 = wr_ok && (idx == `CTMSR_IDX_KEY2);
  assign wr_key3 = wr_ok && (idx == `CTMSR_IDX_KEY3);
  assign wr_mask = wr_ok && (idx == `CTMSR_IDX_IRQ_MASK);
  // Write one to clear the sticky status
  assign clr_stat = wr_ok && (idx == `CTMSR_IDX_IRQ_STAT);

  // ==========================================================
  // Mute status sampling
  // automute flag follow
  always @*
  begin
    mute_d = `CTMSR_RST3;
    mute_d[`CTMSR_MUTE_ANA] = ANALOG_AUTOMUTE_I;
    mute_d[`CTMSR_MUTE_LEFT] = (LEFT_GAIN_I == `CTMSR_GAIN_ZERO);
    mute_d[`CTMSR_MUTE_RIGHT] = (RIGHT_GAIN_I == `CTMSR_GAIN_ZERO);
  end

  always @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      mute_q <= `CTMSR_RST3;
    else
      mute_q <= mute_d;
  end

  // Each flag entering mute is an interrupt event
  assign mute_rise = mute_d & ~mute_q;

  // ==========================================================
  // Read mux and address decode
  // Misaligned or out-of-page addresses count as unmapped accesses
  always @*
  begin
    rd_d = `CTMSR_RST9;
    hit_d = addr_aligned & addr_in_page;
    case (idx)
      `CTMSR_IDX_OUT_OVR: rd_d = ovr_q;
      `CTMSR_IDX_KEY1: rd_d = key1_q;
      `CTMSR_IDX_KEY2: rd_d = key2_q;
      `CTMSR_IDX_KEY3: rd_d = key3_q;
      `CTMSR_IDX_MUTE: rd_d = {{(`CTMSR_RW-`CTMSR_EV_W){1'b0}}, mute_q};
      `CTMSR_IDX_IRQ_STAT: rd_d = {{(`CTMSR_RW-`CTMSR_EV_W){1'b0}}, irq_stat_q};
      `CTMSR_IDX_IRQ_MASK: rd_d = {{(`CTMSR_RW-`CTMSR_EV_W){1'b0}}, irq_mask_q};
      default: hit_d = 1'b0;
    endcase
  end

  // ==========================================================
  // Response value for the coming access cycle
  // Read data is frozen at the setup edge and falls back to zero
  // outside the access cycle, so a stale word never lingers on the bus
  always @*
  begin
    pslverr_d = 1'b0;
    prdata_d = `CTMSR_RST32;
    if (setup_ph)
    begin
      pslverr_d = ~hit_d;
      if (hit_d && !PWRITE_I)
        prdata_d = {{`CTMSR_PAD_W{1'b0}}, rd_d};
    end
  end

  // APB response: ready in the first access cycle, no wait states
  always @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= `CTMSR_RST32;
    end
    else
    begin
      PREADY_O <= setup_ph;
      PSLVERR_O <= pslverr_d;
      PRDATA_O <= prdata_d;
    end
  end

  // ==========================================================
  // Writable registers
  // mute status has no write path
  always @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      ovr_q <= `CTMSR_RST9;
      key1_q <= `CTMSR_RST9;
      key2_q <= `CTMSR_RST9;
      key3_q <= `CTMSR_RST9;
      irq_mask_q <= `CTMSR_RST3;
    end
    else
    begin
      // Mute status index has no strobe, so host writes there are dropped
      if (wr_ovr)
        ovr_q <= PWDATA_I[`CTMSR_RW-1:0];
      if (wr_key1)
        key1_q <= PWDATA_I[`CTMSR_RW-1:0];
      if (wr_key2)
        key2_q <= PWDATA_I[`CTMSR_RW-1:0];
      if (wr_key3)
        key3_q <= PWDATA_I[`CTMSR_RW-1:0];
      if (wr_mask)
        irq_mask_q <= PWDATA_I[`CTMSR_EV_W-1:0];
    end
  end

  // ==========================================================
  // Sticky interrupt status, write one to clear
  // A new event in the clearing cycle wins so no entry is lost
  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (clr_stat)
      irq_stat_d = irq_stat_d & ~PWDATA_I[`CTMSR_EV_W-1:0];
    irq_stat_d = irq_stat_d | mute_rise;
    // Uses the next status so the line rises together with the status bit
    irq_d = |(irq_stat_d & irq_mask_q);
  end

  always @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      irq_stat_q <= `CTMSR_RST3;
      IRQ_O <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      IRQ_O <= irq_d;
    end
  end

  // ==========================================================
  // Tie-off switch control
  // Tie-off switches follow automatic control unless override is enabled; bypass switches keep it and override only adds closes
  assign ovr_en = ovr_q[`CTMSR_OVR_EN];

  // Bypass requests: the forced close applies only while its buffer is off,
  // so an enabled buffer is never shorted by a left-over override bit
  always @*
  begin
    boost_byp_d = AUTO_BOOST_BYP_I;
    if (ovr_en && ovr_q[`CTMSR_OVR_BUFH] && !BOOST_BUF_EN_I)
      boost_byp_d = 1'b1;
    plain_byp_d = AUTO_PLAIN_BYP_I;
    if (ovr_en && ovr_q[`CTMSR_OVR_BUFL] && !PLAIN_BUF_EN_I)
      plain_byp_d = 1'b1;
  end

  // One selector per output switch, same order as the override field
  // override select
  genvar sw;
  generate
    for (sw = 0; sw < `CTMSR_SW_W; sw = sw + 1)
    begin : g_tieoff
      assign tieoff_d[sw] = ovr_en ? ovr_q[`CTMSR_OVR_SW_LO + sw] : AUTO_TIEOFF_I[sw];
    end
  endgenerate

  always @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      BOOST_BYP_CLOSE_O <= 1'b0;
      PLAIN_BYP_CLOSE_O <= 1'b0;
      TIEOFF_CLOSE_O <= `CTMSR_RST6;
    end
    else
    begin
      BOOST_BYP_CLOSE_O <= boost_byp_d;
      PLAIN_BYP_CLOSE_O <= plain_byp_d;
      TIEOFF_CLOSE_O <= tieoff_d;
    end
  end

  // ==========================================================
  // Four-wire mode key check
  // first key value
  // all keys required
  // Full 9-bit compares: a near miss on any key keeps the mode off
  assign key1_ok = (key1_q == `CTMSR_KEY1_VAL);
  assign key2_ok = (key2_q == `CTMSR_KEY2_VAL);
  assign key3_ok = (key3_q == `CTMSR_KEY3_VAL);

  // Mode drops as soon as any key is rewritten to a wrong value
  always @*
  begin
    four_wire_d = key1_ok & key2_ok & key3_ok;
  end

  always @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      FOUR_WIRE_MODE_O <= 1'b0;
    else
      FOUR_WIRE_MODE_O <= four_wire_d;
  end

endmodule

// >>> ctmsr_chk.sv
// Port-level assertions for the tie-off, mute and key register slice
`timescale 1ns/1ps
module ctmsr_chk (
  input wire CLK_I, // Clock
  input wire RESET_N_I, // Reset
  input wire PSEL_I, // Select
  input wire PENABLE_I, // Enable
  input wire PWRITE_I, // Write
  input wire [31:0] PRDATA_O, // Read data
  input wire PREADY_O, // Ready
  input wire PSLVERR_O, // Error
  input wire ANALOG_AUTOMUTE_I, // Automute
  input wire [7:0] LEFT_GAIN_I, // Gain left
  input wire [7:0] RIGHT_GAIN_I, // Gain right
  input wire BOOST_BUF_EN_I, // Buffer on
  input wire PLAIN_BUF_EN_I, // Buffer on
  input wire AUTO_BOOST_BYP_I, // Auto bypass
  input wire AUTO_PLAIN_BYP_I, // Auto bypass
  input wire BOOST_BYP_CLOSE_O, // Bypass
  input wire PLAIN_BYP_CLOSE_O, // Bypass
  input wire FOUR_WIRE_MODE_O, // Mode
  input wire IRQ_O // Interrupt
);
  // ========================================
  // Checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  // Any cause that may raise a mute flag
  wire mute_any = ANALOG_AUTOMUTE_I | (~|LEFT_GAIN_I) | (~|RIGHT_GAIN_I);
  wire wr_done = PWRITE_I & PREADY_O;
  chk_ready_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no ready after setup");
  chk_ready_single: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready held too long");
  chk_err_ready: assert property (PSLVERR_O |-> PREADY_O && PSEL_I)
    else $error("error outside access");
  property p_rdata_zero;
    PRDATA_O[31:9] == 23'h0 && (PREADY_O || PRDATA_O == 32'h0);
  endproperty
  chk_rdata_zero: assert property (p_rdata_zero)
    else $error("read data not zero");
  // Key outputs may move only shortly after a write
  property p_mode_write;
    $changed(FOUR_WIRE_MODE_O) |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  chk_mode_write: assert property (p_mode_write)
    else $error("mode moved without write");
  property p_irq_cause;
    $rose(IRQ_O) |-> $past(mute_any) || $past(mute_any, 2) ||
      $past(PSEL_I) || $past(PSEL_I, 2);
  endproperty
  chk_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without cause");
  // An enabled buffer leaves its bypass to the automatic request
  property p_boost_byp;
    $past(RESET_N_I && (AUTO_BOOST_BYP_I || BOOST_BUF_EN_I)) |->
      BOOST_BYP_CLOSE_O == $past(AUTO_BOOST_BYP_I);
  endproperty
  chk_boost_byp: assert property (p_boost_byp)
    else $error("boosted bypass wrong");
  property p_plain_byp;
    $past(RESET_N_I && (AUTO_PLAIN_BYP_I || PLAIN_BUF_EN_I)) |->
      PLAIN_BYP_CLOSE_O == $past(AUTO_PLAIN_BYP_I);
  endproperty
  chk_plain_byp: assert property (p_plain_byp)
    else $error("plain bypass wrong");
  cover property ($rose(FOUR_WIRE_MODE_O));
  cover property ($rose(IRQ_O));
  cover property (PSLVERR_O);
endmodule
bind ctmsr_regs ctmsr_chk i_ctmsr_chk (
  .CLK_I(CLK_I),
  .RESET_N_I(RESET_N_I),
  .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I),
  .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O),
  .ANALOG_AUTOMUTE_I(ANALOG_AUTOMUTE_I),
  .LEFT_GAIN_I(LEFT_GAIN_I),
  .RIGHT_GAIN_I(RIGHT_GAIN_I),
  .BOOST_BUF_EN_I(BOOST_BUF_EN_I),
  .PLAIN_BUF_EN_I(PLAIN_BUF_EN_I),
  .AUTO_BOOST_BYP_I(AUTO_BOOST_BYP_I),
  .AUTO_PLAIN_BYP_I(AUTO_PLAIN_BYP_I),
  .BOOST_BYP_CLOSE_O(BOOST_BYP_CLOSE_O),
  .PLAIN_BYP_CLOSE_O(PLAIN_BYP_CLOSE_O),
  .FOUR_WIRE_MODE_O(FOUR_WIRE_MODE_O),
  .IRQ_O(IRQ_O)
);

// >>> testbench.sv
// Self-checking bench for the tie-off, mute and key register slice
`timescale 1ns/1ps
module testbench;
  reg CLK_I = 0, RESET_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  reg ANALOG_AUTOMUTE_I = 0, BOOST_BUF_EN_I = 0, PLAIN_BUF_EN_I = 0;
  reg AUTO_BOOST_BYP_I = 0, AUTO_PLAIN_BYP_I = 0;
  reg [11:0] PADDR_I = 0;
  reg [31:0] PWDATA_I = 0, rnd = 32'h82ce;
  reg [7:0] LEFT_GAIN_I = 1, RIGHT_GAIN_I = 1;
  reg [5:0] AUTO_TIEOFF_I = 0;
  wire [31:0] PRDATA_O;
  wire [5:0] TIEOFF_CLOSE_O;
  wire PREADY_O, PSLVERR_O, BOOST_BYP_CLOSE_O, PLAIN_BYP_CLOSE_O, FOUR_WIRE_MODE_O, IRQ_O;
  integer n_fail = 0, cmp_count = 0, i;
  reg [32:0] exp_q [$];
  reg [11:0] amap [0:6] = '{12'h13c, 12'h15c, 12'h1b0, 12'h1cc, 12'h1f0, 12'h1f4, 12'h1f8};
  ctmsr_regs i_ctmsr_regs (
    .CLK_I(CLK_I),
    .RESET_N_I(RESET_N_I),
    .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I),
    .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O),
    .ANALOG_AUTOMUTE_I(ANALOG_AUTOMUTE_I),
    .LEFT_GAIN_I(LEFT_GAIN_I),
    .RIGHT_GAIN_I(RIGHT_GAIN_I),
    .BOOST_BUF_EN_I(BOOST_BUF_EN_I),
    .PLAIN_BUF_EN_I(PLAIN_BUF_EN_I),
    .AUTO_BOOST_BYP_I(AUTO_BOOST_BYP_I),
    .AUTO_PLAIN_BYP_I(AUTO_PLAIN_BYP_I),
    .AUTO_TIEOFF_I(AUTO_TIEOFF_I),
    .BOOST_BYP_CLOSE_O(BOOST_BYP_CLOSE_O),
    .PLAIN_BYP_CLOSE_O(PLAIN_BYP_CLOSE_O),
    .TIEOFF_CLOSE_O(TIEOFF_CLOSE_O),
    .FOUR_WIRE_MODE_O(FOUR_WIRE_MODE_O),
    .IRQ_O(IRQ_O)
  );
  // ========================================
  // Clock and helpers
  always #20 CLK_I = ~CLK_I;
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [32:0] seen, input [32:0] want);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== want)
    begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  end
  endtask
  task stop_test;
  begin
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask
  // Setup, then hold the access until ready is sampled high
  task apb(input w, input [11:0] a, input [8:0] d, input [32:0] e);
  begin
    @(posedge CLK_I);
    PSEL_I <= 1'h1;
    PWRITE_I <= w;
    PADDR_I <= a;
    PWDATA_I <= {rnd[31:9], d};
    if (!w)
      exp_q.push_back(e);
    @(posedge CLK_I);
    PENABLE_I <= 1'h1;
    @(posedge CLK_I);
    while (!PREADY_O)
      @(posedge CLK_I);
    PSEL_I <= 1'h0;
    PENABLE_I <= 1'h0;
  end
  endtask
  task wr(input [11:0] a, input [8:0] d);
    apb(1'h1, a, d, 33'h0);
  endtask
  task rd(input [11:0] a, input [8:0] v);
    apb(1'h0, a, 9'h0, {24'h0, v});
  endtask
  // Margin past the one-edge output latency
  task settle;
  begin
    repeat (3) @(posedge CLK_I);
    #1;
  end
  endtask
  // Oldest read note against what the slave returns
  always @(posedge CLK_I)
    if (PREADY_O && !PWRITE_I)
      chk({PSLVERR_O, PRDATA_O}, exp_q.pop_front());
  // Watchdog; the run needs under two hundred cycles
  initial
  begin
    #100000;
    n_fail = n_fail + 1;
    stop_test;
  end
  // ========================================
  // Scenarios
  initial
  begin
    repeat (10) @(posedge CLK_I);
    RESET_N_I <= 1'h1;
    // Reset values, then unmapped and misaligned places refused
    for (i = 0; i < 7; i = i + 1)
      rd(amap[i], 9'h0);
    apb(1'h0, 12'h200, 9'h0, {1'h1, 32'h0});
    apb(1'h0, 12'h13d, 9'h0, {1'h1, 32'h0});
    // Top address bit set: would alias the override register if undecoded
    apb(1'h0, 12'h93c, 9'h0, {1'h1, 32'h0});
    // Override off follows automatic requests, on forces the bits
    for (i = 0; i < 8; i = i + 1)
    begin
      rnd = lfsr(rnd);
      wr(amap[0], {i[0], rnd[13:6]});
      {PLAIN_BUF_EN_I, BOOST_BUF_EN_I, AUTO_PLAIN_BYP_I, AUTO_BOOST_BYP_I} <= rnd[17:14];
      AUTO_TIEOFF_I <= rnd[5:0];
      settle;
      chk(TIEOFF_CLOSE_O, i[0] ? rnd[11:6] : rnd[5:0]);
      chk(BOOST_BYP_CLOSE_O, rnd[14] | i[0] & rnd[13] & !rnd[16]);
      chk(PLAIN_BYP_CLOSE_O, rnd[15] | i[0] & rnd[12] & !rnd[17]);
      rd(amap[0], {i[0], rnd[13:6]});
    end
    // Mode only while all three keys hold their values
    wr(amap[1], 9'h115);
    wr(amap[2], 9'h03b);
    settle;
    chk(FOUR_WIRE_MODE_O, 1'h0);
    wr(amap[3], 9'h129);
    settle;
    chk(FOUR_WIRE_MODE_O, 1'h1);
    wr(amap[2], 9'h03a);
    settle;
    chk(FOUR_WIRE_MODE_O, 1'h0);
    // Mute causes set sticky status; mask gates the line; write one clears
    wr(amap[6], 9'h7);
    LEFT_GAIN_I <= 8'h00;
    ANALOG_AUTOMUTE_I <= 1'h1;
    settle;
    chk(IRQ_O, 1'h1);
    wr(amap[4], 9'h1ff);
    rd(amap[4], 9'h6);
    wr(amap[6], 9'h1);
    settle;
    chk(IRQ_O, 1'h0);
    rd(amap[5], 9'h6);
    RIGHT_GAIN_I <= 8'h00;
    settle;
    chk(IRQ_O, 1'h1);
    wr(amap[5], 9'h7);
    {LEFT_GAIN_I, RIGHT_GAIN_I} <= {rnd[7:1], 1'h1, rnd[15:9], 1'h1};
    ANALOG_AUTOMUTE_I <= 1'h0;
    settle;
    chk(IRQ_O, 1'h0);
    rd(amap[5], 9'h0);
    rd(amap[4], 9'h0);
    settle;
    stop_test;
  end
endmodule
